// File: include/trp_buf_if.sv
/*
 * valid/ready link between the host port and its two-entry byte buffer.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface trp_buf_if #(parameter int unsigned WIDTH = 8);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;
    logic             flush;
    modport fifo (input in_valid, in_data, out_ready, flush,
                  output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, flush,
                  input in_ready, out_valid, out_data);
endinterface : trp_buf_if
`default_nettype wire

// File: include/trp_pkg.sv
/*
 * constants, status layout, command codes and state type of the
 * recorder host port.
 * assumes a single 200 MHz clock; print and advance times are turned into cycle counts here.
 */
`default_nettype none
package trp_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned PRINT_TIME_US  = 2500;
    localparam int unsigned ADV_TIME_US    = 4000;
    localparam int unsigned LOAD_TIME_NS   = 5000;
    localparam int unsigned PRINT_CYC      = PRINT_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned ADV_CYC        = ADV_TIME_US * 1000 / CLK_PERIOD_NS;
    // a line of 384 dots at 40 dots per segment gives ten segments
    localparam int unsigned SEG_NOMINAL    = 10;
    localparam int unsigned STRIKE_CYC     = PRINT_CYC / SEG_NOMINAL;
    // a byte must be shifted long before the load time runs out
    localparam int unsigned SHIFT_DIV      = 16;
    localparam int unsigned TMR_W          = 20;

    localparam int unsigned LINE_DOTS      = 384;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned ADDR_W         = 4;
    localparam int unsigned SEG_W          = 10;
    localparam int unsigned DOTS_W         = 6;
    localparam int unsigned STRIKE_W       = 4;

    localparam logic [DOTS_W-1:0]   DOTS_MIN    = 6'h0D;
    localparam logic [DOTS_W-1:0]   DOTS_MAX    = 6'h29;
    localparam logic [DOTS_W-1:0]   DOTS_RST    = 6'h28;
    localparam logic [STRIKE_W-1:0] STRIKES_RST = 4'h1;

    localparam logic [ADDR_W-1:0] ADDR_IDENT    = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h1;
    localparam logic [ADDR_W-1:0] CMD_RESET     = 4'h0;
    localparam logic [ADDR_W-1:0] CMD_ADVANCE   = 4'h1;
    localparam logic [ADDR_W-1:0] CMD_LOAD      = 4'h2;
    localparam logic [ADDR_W-1:0] CMD_LATCH     = 4'h3;
    localparam logic [ADDR_W-1:0] CMD_PRINT_ADV = 4'h4;
    localparam logic [ADDR_W-1:0] CMD_PRINT     = 4'h5;

    localparam int unsigned ST_ADV_RDY   = 4;
    localparam int unsigned ST_DATA_RDY  = 5;
    localparam int unsigned ST_PRINT_RDY = 6;
    localparam int unsigned ST_NO_FAULT  = 7;

    // sync vector {addr, data, select, read, write, button, fault}
    localparam int unsigned       SYNC_W   = 17;
    localparam logic [SYNC_W-1:0] SYNC_RST = 17'h0_001E;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_PRINT   = 2'b01,
        ST_ADVANCE = 2'b10
    } trp_state_e;
endpackage : trp_pkg
`default_nettype wire

// File: rtl/trp_buf2.sv
/*
 * two-entry valid/ready buffer for print bytes.
 * assumes the user holds in_data with in_valid; flush empties it at once.
 */
`timescale 1ns/100ps
`default_nettype none
module trp_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic clk,
    input  wire logic rst_n,
    trp_buf_if.fifo   b
);
    logic [WIDTH-1:0] mem_q [2];
    logic             wr_ptr_q;
    logic             rd_ptr_q;
    logic [1:0]       count_q;
    wire              push = b.in_valid & b.in_ready;
    wire              pop  = b.out_valid & b.out_ready;

    assign b.in_ready  = (count_q != 2'h2);
    assign b.out_valid = (count_q != 2'h0);
    assign b.out_data  = mem_q[rd_ptr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= b.in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else if (b.flush) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            count_q  <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : trp_buf2
`default_nettype wire

// File: rtl/trp_host_port.sv
/*
 * parallel host command port of a thermal line recorder: identification
 * and status reads, command writes, byte loading, line latch and segmented
 * printing with paper advance.
 * assumes host pins are asynchronous to clk and are synchronised here; the
 * fault level and button come from pins; configuration comes from logic on clk.
 */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R01 - read at address 0 returns the fixed identification byte
// R02 - read at address 1 returns the status byte
// R03 - status bits 0 to 3 carry no meaning, driven as zero
// R04 - status bit 4 is one when an advance can be accepted
// R05 - status bit 6 is one when a print can be accepted
// R06 - status bit 7 is zero while a fault exists
// R07 - write at address 0 returns the recorder to idle
// R08 - write at address 1 steps paper one line, no dots energised
// R09 - write at address 2 shifts the data byte into the head line
// R10 - write at address 3 copies the loaded line into the head latch
// R11 - write at address 4 prints the latched line then advances
// R12 - write at address 5 prints the latched line without advance
// R13 - head has 384 dots, each driven by one latched bit
// R14 - line is energised in segments of at most the set dot count
// R15 - dots per segment are configurable from 13 to 41
// R16 - strikes per segment are configurable
// R17 - after power-up: forty dots and one strike per segment
// R18 - status bit 5 is one when more print data can be taken
// R19 - host drives address and pulses select with read or write low
// R20 - button press asserts the request low; bus access keeps working
// R21 - print takes about 2.5 ms, advance 4 ms, load and latch under 5 us
// R22 - reads at 2 to 15 and writes at 6 to 15 change nothing
// R23 - a ready flag drops on acceptance and returns when done
module trp_host_port #(
    parameter logic [7:0]  ID_CODE    = 8'h5A,  // arbitrary identification value
    parameter int unsigned STRIKE_CYC = trp_pkg::STRIKE_CYC,
    parameter int unsigned ADV_CYC    = trp_pkg::ADV_CYC
) (
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    input  wire logic [trp_pkg::ADDR_W-1:0]           addr_pin,
    input  wire logic [trp_pkg::BYTE_W-1:0]           data_in,
    output var  logic [trp_pkg::BYTE_W-1:0]           data_out,
    output var  logic                                 data_oe_n,
    input  wire logic                                 recorder_select_n,
    input  wire logic                                 read_n,
    input  wire logic                                 write_n,
    input  wire logic                                 record_button_n,
    input  wire logic                                 fault_pin,
    input  wire logic                                 cfg_load,
    input  wire logic [trp_pkg::DOTS_W-1:0]           cfg_dots,
    input  wire logic [trp_pkg::STRIKE_W-1:0]         cfg_strikes,
    output var  logic [trp_pkg::LINE_DOTS-1:0]        head_fire,
    output var  logic                                 motor_step,
    output var  logic                                 record_button_request_n
);
    localparam int unsigned LD = trp_pkg::LINE_DOTS;
    localparam int unsigned BW = trp_pkg::BYTE_W;

    logic [trp_pkg::SYNC_W-1:0]   sync1_q, sync2_q;
    logic [trp_pkg::ADDR_W-1:0]   cmd_addr_q;
    logic [BW-1:0]                cmd_data_q;
    logic                         wr_act_q;
    logic [BW-1:0]                data_out_q;
    logic                         data_oe_n_q;
    logic                         req_n_q;
    logic [3:0]                   div_q;
    logic [LD-1:0]                shift_line_q, line_latch_q, head_fire_q;
    trp_pkg::trp_state_e          state_q, state_d;
    logic [trp_pkg::SEG_W-1:0]    seg_base_q;
    logic [trp_pkg::STRIKE_W-1:0] strike_q;
    logic [trp_pkg::TMR_W-1:0]    tmr_q;
    logic                         adv_pending_q;
    logic                         motor_step_q;
    logic [trp_pkg::DOTS_W-1:0]   dots_q;
    logic [trp_pkg::STRIKE_W-1:0] strikes_q;
    logic [LD-1:0]                seg_mask;

    trp_buf_if #(.WIDTH(BW)) bif ();

    trp_buf2 #(.WIDTH(BW)) u_buf (
        .clk   (clk),
        .rst_n (rst_n),
        .b     (bif)
    );

    // pin decode after the two-stage synchroniser
    wire [trp_pkg::ADDR_W-1:0] addr_s = sync2_q[16:13];
    wire [BW-1:0] data_s  = sync2_q[12:5];
    wire          sel_n_s = sync2_q[4];
    wire          rd_n_s  = sync2_q[3];
    wire          wr_n_s  = sync2_q[2];
    wire          btn_n_s = sync2_q[1];
    wire          fault_s = sync2_q[0];
    wire          rd_act  = ~sel_n_s & ~rd_n_s;
    wire          wr_act  = ~sel_n_s & ~wr_n_s;
    // commands act at the strobe's end so address and data have settled
    wire          wr_end  = wr_act_q & ~wr_act;

    wire cmd_reset  = wr_end & (cmd_addr_q == trp_pkg::CMD_RESET);
    wire cmd_adv    = wr_end & (cmd_addr_q == trp_pkg::CMD_ADVANCE);
    wire cmd_load   = wr_end & (cmd_addr_q == trp_pkg::CMD_LOAD);
    wire cmd_latch  = wr_end & (cmd_addr_q == trp_pkg::CMD_LATCH);
    wire cmd_pr_adv = wr_end & (cmd_addr_q == trp_pkg::CMD_PRINT_ADV);
    wire cmd_print  = wr_end & (cmd_addr_q == trp_pkg::CMD_PRINT);
    wire idle       = (state_q == trp_pkg::ST_IDLE);
    wire start_pr   = idle & (cmd_pr_adv | cmd_print);              // see R11 see R12
    wire start_adv  = idle & cmd_adv;                               // see R08

    wire adv_ready   = idle;                                        // see R04 see R23
    wire print_ready = idle;                                        // see R05 see R23
    wire data_ready  = ~bif.out_valid;                              // see R18 see R23
    wire [BW-1:0] status_byte = {~fault_s, print_ready, data_ready, // see R06
                                 adv_ready, 4'h0};                  // see R03
    wire [BW-1:0] read_mux = (addr_s == trp_pkg::ADDR_IDENT)  ? ID_CODE     : // see R01
                             (addr_s == trp_pkg::ADDR_STATUS) ? status_byte : // see R02
                             8'h00;                                           // see R22

    // byte path: host writes fill the buffer, the shifter drains it slowly
    wire shift_en = (div_q == 4'(trp_pkg::SHIFT_DIV - 1));
    assign bif.in_valid  = cmd_load;                                // see R09
    assign bif.in_data   = cmd_data_q;
    assign bif.out_ready = shift_en;
    assign bif.flush     = cmd_reset;                               // see R07
    wire shift_now = bif.out_valid & shift_en;

    // segment window over the latched line
    wire [trp_pkg::SEG_W-1:0] seg_end  = seg_base_q + {4'h0, dots_q};
    wire                      seg_last = (seg_end >= 10'(LD));
    wire                      strike_end = (tmr_q == 20'(STRIKE_CYC - 1));
    wire                      adv_end    = (tmr_q == 20'(ADV_CYC - 1));
    wire                      last_strike = (strike_q == strikes_q - 4'h1);

    genvar gi;
    generate
        for (gi = 0; gi < LD; gi++) begin : g_mask
            assign seg_mask[gi] = (10'(gi) >= seg_base_q) && (10'(gi) < seg_end); // see R14
        end
    endgenerate

    wire [trp_pkg::DOTS_W-1:0] dots_clamp =
        (cfg_dots < trp_pkg::DOTS_MIN) ? trp_pkg::DOTS_MIN :
        (cfg_dots > trp_pkg::DOTS_MAX) ? trp_pkg::DOTS_MAX : cfg_dots;           // see R15
    wire [trp_pkg::STRIKE_W-1:0] strikes_clamp =
        (cfg_strikes == 4'h0) ? trp_pkg::STRIKES_RST : cfg_strikes;               // see R16

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            trp_pkg::ST_IDLE: begin
                if (start_pr) begin
                    state_d = trp_pkg::ST_PRINT;
                end else if (start_adv) begin
                    state_d = trp_pkg::ST_ADVANCE;
                end
            end
            trp_pkg::ST_PRINT: begin
                if (strike_end && last_strike && seg_last) begin
                    state_d = adv_pending_q ? trp_pkg::ST_ADVANCE : trp_pkg::ST_IDLE; // see R11
                end
            end
            trp_pkg::ST_ADVANCE: begin
                if (adv_end) begin
                    state_d = trp_pkg::ST_IDLE;                     // see R21
                end
            end
            default: state_d = trp_pkg::ST_IDLE;
        endcase
        if (cmd_reset) begin
            state_d = trp_pkg::ST_IDLE;                             // see R07
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= trp_pkg::SYNC_RST;
            sync2_q <= trp_pkg::SYNC_RST;
        end else begin
            sync1_q <= {addr_pin, data_in, recorder_select_n, read_n, write_n,
                        record_button_n, fault_pin};                // see R19
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_act_q   <= 1'b0;
            cmd_addr_q <= 4'h0;
            cmd_data_q <= 8'h00;
        end else begin
            wr_act_q <= wr_act;
            if (wr_act) begin
                cmd_addr_q <= addr_s;
                cmd_data_q <= data_s;
            end
        end
    end

    // reads never touch recorder state, and the request never blocks them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out_q  <= 8'h00;
            data_oe_n_q <= 1'b1;
            req_n_q     <= 1'b1;
        end else begin
            data_out_q  <= read_mux;
            data_oe_n_q <= ~rd_act;
            req_n_q     <= btn_n_s;                                 // see R20
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 4'h0;
        end else begin
            div_q <= shift_en ? 4'h0 : div_q + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_line_q <= '0;
            line_latch_q <= '0;
        end else begin
            if (shift_now) begin
                shift_line_q <= {shift_line_q[LD-BW-1:0], bif.out_data}; // see R09
            end
            if (cmd_latch) begin
                line_latch_q <= shift_line_q;                       // see R10
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dots_q    <= trp_pkg::DOTS_RST;                         // see R17
            strikes_q <= trp_pkg::STRIKES_RST;
        end else if (cfg_load) begin
            dots_q    <= dots_clamp;
            strikes_q <= strikes_clamp;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q       <= trp_pkg::ST_IDLE;
            seg_base_q    <= '0;
            strike_q      <= '0;
            tmr_q         <= '0;
            adv_pending_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                tmr_q      <= '0;
                seg_base_q <= '0;
                strike_q   <= '0;
            end else if (state_q == trp_pkg::ST_PRINT && strike_end) begin
                tmr_q    <= '0;
                strike_q <= last_strike ? 4'h0 : strike_q + 4'h1;   // see R16
                if (last_strike) begin
                    seg_base_q <= seg_end;
                end
            end else if (state_q != trp_pkg::ST_IDLE) begin
                tmr_q <= tmr_q + 20'h0_0001;
            end
            if (start_pr) begin
                adv_pending_q <= cmd_pr_adv;                        // see R12
            end else if (cmd_reset || state_q == trp_pkg::ST_ADVANCE) begin
                adv_pending_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_fire_q  <= '0;
            motor_step_q <= 1'b0;
        end else begin
            head_fire_q  <= (state_q == trp_pkg::ST_PRINT) ? (line_latch_q & seg_mask) : '0; // see R13
            motor_step_q <= (state_d == trp_pkg::ST_ADVANCE) && (state_q != trp_pkg::ST_ADVANCE);
        end
    end

    assign data_out                = data_out_q;
    assign data_oe_n               = data_oe_n_q;
    assign head_fire               = head_fire_q;
    assign motor_step              = motor_step_q;
    assign record_button_request_n = req_n_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_print_cmd;
        idle && wr_end && (cmd_addr_q == trp_pkg::CMD_PRINT);
    endsequence
    property p_ident;
        (addr_s == trp_pkg::ADDR_IDENT) |=> (data_out_q == ID_CODE);
    endproperty
    a_ident: assert property (p_ident) else $error("identification byte wrong"); // see R01
    property p_status;
        (addr_s == trp_pkg::ADDR_STATUS) |=> (data_out_q == $past(status_byte));
    endproperty
    a_status: assert property (p_status) else $error("status byte wrong"); // see R02
    property p_fault;
        (addr_s == trp_pkg::ADDR_STATUS) && fault_s |=> !data_out_q[trp_pkg::ST_NO_FAULT];
    endproperty
    a_fault: assert property (p_fault) else $error("fault not shown"); // see R06
    property p_reset_cmd;
        cmd_reset |=> (state_q == trp_pkg::ST_IDLE) && !bif.out_valid;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored"); // see R07
    property p_adv_dark;
        (state_q == trp_pkg::ST_ADVANCE) |=> (head_fire_q == '0);
    endproperty
    a_adv_dark: assert property (p_adv_dark) else $error("dots fired in advance"); // see R08
    property p_latch;
        cmd_latch |=> (line_latch_q == $past(shift_line_q));
    endproperty
    a_latch: assert property (p_latch) else $error("line not latched"); // see R10
    property p_no_adv;
        s_print_cmd |=> (state_q == trp_pkg::ST_PRINT) && !adv_pending_q;
    endproperty
    a_no_adv: assert property (p_no_adv) else $error("print without advance wrong"); // see R12
    property p_seg_limit;
        $countones(head_fire_q) <= int'(dots_q);
    endproperty
    a_seg_limit: assert property (p_seg_limit) else $error("segment too wide"); // see R14
    property p_dots_range;
        (dots_q >= trp_pkg::DOTS_MIN) && (dots_q <= trp_pkg::DOTS_MAX);
    endproperty
    a_dots_range: assert property (p_dots_range) else $error("dot count out of range"); // see R15
    property p_ready_drop;
        start_pr |=> !print_ready [*2];
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("print ready stayed high"); // see R23
    property p_request;
        !btn_n_s |=> !req_n_q;
    endproperty
    a_request: assert property (p_request) else $error("request not raised"); // see R20
endmodule : trp_host_port
`default_nettype wire

// File: verification/trp_host_model.sv
/*
 * host processor model: drives address, strobes and write data on the bus.
 * assumes the bench calls cyc once per bus cycle; it resolves the data wire.
 */
`timescale 1ns/100ps
`default_nettype none
module trp_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    output var  logic [3:0] addr_pin,
    output var  logic [7:0] data_in,
    output var  logic       recorder_select_n,
    output var  logic       read_n,
    output var  logic       write_n
);
    logic [7:0] drv_q = 8'h00;
    logic       drv_en = 1'b0;
    // a released wire shows the inverse of our last value, never a stale copy
    always_comb data_in = !data_oe_n ? data_out : (drv_en ? drv_q : ~drv_q);
    initial begin
        addr_pin = 4'h0;
        recorder_select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
    end
    // strobes held six edges so the synchronised answer has settled
    task automatic cyc(input logic [3:0] a, input logic [7:0] d, input logic wr,
                       output logic [7:0] q);
        @(negedge clk);
        addr_pin = a;
        drv_q = d;
        drv_en = wr;
        recorder_select_n = 1'b0;
        read_n = wr;
        write_n = !wr;
        repeat (6) @(posedge clk);
        q = data_in;
        @(negedge clk);
        recorder_select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        drv_en = 1'b0;
        repeat (5) @(negedge clk);
    endtask : cyc
endmodule : trp_host_model
`default_nettype wire

// File: verification/trp_host_port_tb.sv
/*
 * self-checking bench of the host port: reads, loads, prints, advance,
 * reset command, button request and segment configuration.
 * assumes the host model owns the bus pins.
 */
`timescale 1ns/100ps
`default_nettype none
module trp_host_port_tb;
    localparam logic [7:0] ID = 8'h3C;  // arbitrary identification value
    localparam int         STRIKE_SIM = 20;  // short strike so prints fit the run
    logic         clk;
    logic         rst_n;
    logic         fault_pin;
    logic         record_button_n;
    logic         cfg_load;
    logic [5:0]   cfg_dots;
    logic [3:0]   cfg_strikes;
    logic [3:0]   addr_pin;
    logic [7:0]   data_in;
    logic [7:0]   data_out;
    logic         data_oe_n;
    logic         recorder_select_n;
    logic         read_n;
    logic         write_n;
    logic [383:0] head_fire;
    logic [383:0] fired;
    logic [383:0] line;
    logic         motor_step;
    logic         record_button_request_n;
    logic [7:0]   q;
    logic [31:0]  lfsr = 32'h0001_0391;
    int           seg_max;
    int           steps;
    int           fire_cyc;
    int           c1;
    int           bad_count;
    int           check_count;

    trp_host_port #(.ID_CODE(ID), .STRIKE_CYC(STRIKE_SIM), .ADV_CYC(30)) dut (
        .clk, .rst_n, .addr_pin, .data_in, .data_out, .data_oe_n, .recorder_select_n,
        .read_n, .write_n, .record_button_n, .fault_pin, .cfg_load, .cfg_dots,
        .cfg_strikes, .head_fire, .motor_step, .record_button_request_n);
    trp_host_model host (
        .clk, .data_out, .data_oe_n, .addr_pin, .data_in, .recorder_select_n,
        .read_n, .write_n);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        fired <= fired | head_fire;
        seg_max <= ($countones(head_fire) > seg_max) ? $countones(head_fire) : seg_max;
        steps <= steps + int'(motor_step === 1'b1);
        fire_cyc <= fire_cyc + int'(head_fire !== '0);
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    function automatic logic [7:0] stat(input logic flt, input logic idle);
        return {!flt, idle, 1'b1, idle, 4'h0};
    endfunction : stat
    function automatic int segs(input int d);
        return (384 + d - 1) / d;
    endfunction : segs
    task automatic chk(input logic [383:0] got, input logic [383:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.cyc(a, d, 1'b1, q);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        host.cyc(a, 8'h00, 1'b0, q);
    endtask : rd
    task automatic clr();
        @(negedge clk);
        fired = '0;
        seg_max = 0;
        steps = 0;
        fire_cyc = 0;
    endtask : clr
    task automatic cfg(input logic [5:0] d, input logic [3:0] s);
        cfg_dots = d;
        cfg_strikes = s;
        cfg_load = 1'b1;
        @(negedge clk);
        cfg_load = 1'b0;
    endtask : cfg
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            rd(trp_pkg::ADDR_STATUS);
            n++;
        end while (q[6] !== 1'b1 && n < 300);
        chk(q, stat(1'b0, 1'b1));
    endtask : wait_idle
    // spacing keeps the two-entry buffer from ever filling
    task automatic load_line(input logic ones);
        logic [7:0] b;
        for (int i = 0; i < 48; i++) begin
            b = ones ? 8'hFF : 8'(rnd());
            line = {line[375:0], b};
            wr(trp_pkg::CMD_LOAD, b);
            repeat (6) @(negedge clk);
        end
        repeat (32) @(negedge clk);
        wr(trp_pkg::CMD_LATCH, 8'h00);
    endtask : load_line
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        fault_pin = 1'b0;
        record_button_n = 1'b1;
        cfg_load = 1'b0;
        cfg_dots = 6'h28;
        cfg_strikes = 4'h1;
        bad_count = 0;
        check_count = 0;
        line = '0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk({motor_step, record_button_request_n, data_oe_n}, 3'b011);
        rd(trp_pkg::ADDR_IDENT);
        chk(q, ID);
        rd(trp_pkg::ADDR_STATUS);
        chk(q, stat(1'b0, 1'b1));
        for (int a = 2; a < 16; a++) begin
            rd(4'(a));
            chk(q, 8'h00);
        end
        fault_pin = 1'b1;
        rd(trp_pkg::ADDR_STATUS);
        chk(q, stat(1'b1, 1'b1));
        fault_pin = 1'b0;
        record_button_n = 1'b0;
        rd(trp_pkg::ADDR_IDENT);
        chk({record_button_request_n, q}, {1'b0, ID});
        record_button_n = 1'b1;
        load_line(1'b0);
        clr();
        wr(trp_pkg::CMD_PRINT, 8'h00);
        rd(trp_pkg::ADDR_STATUS);
        chk(q, stat(1'b0, 1'b0));
        wait_idle();
        chk(fired, line);
        chk(steps, 0);
        chk(seg_max <= 40, 1'b1);
        load_line(1'b1);
        clr();
        wr(trp_pkg::CMD_PRINT_ADV, 8'h00);
        wait_idle();
        chk(fired, line);
        chk(seg_max, 40);
        chk(steps, 1);
        c1 = fire_cyc;
        chk(c1, segs(40) * STRIKE_SIM);
        cfg(6'h0D, 4'h2);
        clr();
        wr(trp_pkg::CMD_PRINT, 8'h00);
        wait_idle();
        chk(seg_max, 13);
        chk(fire_cyc, c1 / segs(40) * segs(13) * 2);
        // corner: too many dots clamps to 41, zero strikes counts as one
        cfg(6'h3F, 4'h0);
        clr();
        wr(trp_pkg::CMD_PRINT, 8'h00);
        wait_idle();
        chk(seg_max, 41);
        chk(fire_cyc, segs(41) * STRIKE_SIM);
        // mid-run reset must bring back forty dots and one strike
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk({motor_step, record_button_request_n, data_oe_n}, 3'b011);
        load_line(1'b1);
        clr();
        wr(trp_pkg::CMD_PRINT, 8'h00);
        wait_idle();
        chk(seg_max, 40);
        chk(fire_cyc, segs(40) * STRIKE_SIM);
        chk(fired, line);
        clr();
        wr(trp_pkg::CMD_ADVANCE, 8'h00);
        rd(trp_pkg::ADDR_STATUS);
        chk(q, stat(1'b0, 1'b0));
        wait_idle();
        chk(steps, 1);
        chk(fired, '0);
        wr(trp_pkg::CMD_PRINT, 8'h00);
        wr(trp_pkg::CMD_RESET, 8'h00);
        rd(trp_pkg::ADDR_STATUS);
        chk(q, stat(1'b0, 1'b1));
        clr();
        for (int a = 6; a < 16; a++) wr(4'(a), 8'(rnd()));
        rd(trp_pkg::ADDR_STATUS);
        chk(q, stat(1'b0, 1'b1));
        chk(steps + fire_cyc, 0);
        wrap_up();
    end
endmodule : trp_host_port_tb
`default_nettype wire
